// [pkg/sscw_pkg.sv]
package sscw_pkg;

  // control word geometry
  localparam int          WORD_W      = 24;
  localparam int          DIVR_W      = 12;
  localparam int          REFR_W      = 5;
  localparam int          REFF_W      = 14;
  localparam int          SYNF_W      = 21;
  localparam int          PCF_W       = 10;

  // main divider base ratio, 2176
  localparam logic [11:0] DIV_BASE    = 12'h880;

  // phase comparator rate in kHz, 0.864 MHz
  localparam logic [9:0]  PC_FREQ_KHZ = 10'h360;

  // reference select codes and ratios
  localparam logic [1:0]  REF_SEL_0   = 2'h0;
  localparam logic [1:0]  REF_SEL_1   = 2'h1;
  localparam logic [1:0]  REF_SEL_2   = 2'h2;
  localparam logic [4:0]  REF_RATIO_0 = 5'h04;
  localparam logic [4:0]  REF_RATIO_1 = 5'h10;
  localparam logic [4:0]  REF_RATIO_2 = 5'h08;
  localparam logic [4:0]  REF_RATIO_3 = 5'h0C;

  // first in at the top, last in at bit zero
  typedef struct packed {
    logic [3:0] test_hi;
    logic       slicer_force;
    logic [1:0] ref_div_sel;
    logic [6:0] test_lo;
    logic       serial_power_sel;
    logic       pll_hold;
    logic       ext_mode_sel;
    logic       tx_rx_sel;
    logic [5:0] div_field;
  } sscw_ctl_word_t;

  localparam sscw_ctl_word_t CTL_RESET = 24'h000000;

  typedef enum logic [1:0] {
    SSCW_MODE_RSVD     = 2'h0,
    SSCW_MODE_NORMAL   = 2'h1,
    SSCW_MODE_REDUCED  = 2'h2,
    SSCW_MODE_ADVANCED = 2'h3
  } sscw_mode_t;

endpackage

// [src/sscw_top.sv]
`timescale 1ns/10ps
module sscw_top (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          ce,
  input  wire logic                          ser_clk,
  input  wire logic                          ser_data,
  input  wire logic                          ser_en_b,
  input  wire logic                          osc_power_on,
  input  wire logic                          slicer_hold_ctl,
  output logic        [sscw_pkg::DIVR_W-1:0] main_div_ratio,
  output logic        [sscw_pkg::REFR_W-1:0] ref_div_ratio,
  output logic        [sscw_pkg::REFF_W-1:0] ref_freq_khz,
  output logic        [sscw_pkg::SYNF_W-1:0] synth_freq_khz,
  output sscw_pkg::sscw_mode_t               op_mode,
  output logic                               mode_reserved,
  output logic                               tx_rx_sel,
  output logic                               pll_keep_on,
  output logic                               slicer_on,
  output logic                               slicer_res_route,
  output logic                               demod_direct,
  output logic                               slicer_ref_follow,
  output logic                               test_bits_err,
  output logic                               word_loaded
);

  function automatic logic [11:0] div_ratio_of(sscw_pkg::sscw_ctl_word_t w);
    div_ratio_of = sscw_pkg::DIV_BASE + {5'h00, w.div_field, w.tx_rx_sel};
  endfunction

  function automatic logic [4:0] ref_ratio_of(logic [1:0] sel);
    if (sel == sscw_pkg::REF_SEL_0) begin
      ref_ratio_of = sscw_pkg::REF_RATIO_0;
    end else if (sel == sscw_pkg::REF_SEL_1) begin
      ref_ratio_of = sscw_pkg::REF_RATIO_1;
    end else if (sel == sscw_pkg::REF_SEL_2) begin
      ref_ratio_of = sscw_pkg::REF_RATIO_2;
    end else begin
      ref_ratio_of = sscw_pkg::REF_RATIO_3;
    end
  endfunction

  function automatic logic [20:0] synth_khz_of(logic [11:0] ratio);
    synth_khz_of = {9'h000, ratio} * {11'h000, sscw_pkg::PC_FREQ_KHZ};
  endfunction

  function automatic logic [13:0] ref_khz_of(logic [4:0] ratio);
    ref_khz_of = {9'h000, ratio} * {4'h0, sscw_pkg::PC_FREQ_KHZ};
  endfunction

  function automatic sscw_pkg::sscw_mode_t mode_of(logic pwr, logic ext);
    case ({pwr, ext})
      2'h0:    mode_of = sscw_pkg::SSCW_MODE_NORMAL;
      2'h1:    mode_of = sscw_pkg::SSCW_MODE_REDUCED;
      2'h3:    mode_of = sscw_pkg::SSCW_MODE_ADVANCED;
      default: mode_of = sscw_pkg::SSCW_MODE_RSVD;
    endcase
  endfunction

  // link side: serial shift register on the serial clock
  logic [sscw_pkg::WORD_W-1:0] shift_r;
  logic [sscw_pkg::WORD_W-1:0] shift_nxt;

  always_comb begin
    if (ser_en_b) begin
      shift_nxt = shift_r;
    end else begin
      shift_nxt = {shift_r[sscw_pkg::WORD_W-2:0], ser_data};
    end
  end

  // data and enable change on the falling edge, so sample on the rising one
  always_ff @(posedge ser_clk) begin
    shift_r <= shift_nxt;
  end

  // core side
  logic                          en_meta_r;
  logic                          en_meta_nxt;
  logic                          en_sync_r;
  logic                          en_sync_nxt;
  logic                          en_prev_r;
  logic                          en_prev_nxt;
  logic                          osc_meta_r;
  logic                          osc_meta_nxt;
  logic                          osc_sync_r;
  logic                          osc_sync_nxt;
  logic                          hold_meta_r;
  logic                          hold_meta_nxt;
  logic                          hold_sync_r;
  logic                          hold_sync_nxt;
  logic                          load;
  sscw_pkg::sscw_ctl_word_t      ctl_r;
  sscw_pkg::sscw_ctl_word_t      ctl_nxt;
  logic [sscw_pkg::DIVR_W-1:0]   main_div_nxt;
  logic [sscw_pkg::REFR_W-1:0]   ref_div_nxt;
  logic [sscw_pkg::REFF_W-1:0]   ref_freq_nxt;
  logic [sscw_pkg::SYNF_W-1:0]   synth_freq_nxt;
  sscw_pkg::sscw_mode_t          op_mode_nxt;
  logic                          mode_rsvd_nxt;
  logic                          tx_rx_nxt;
  logic                          pll_keep_nxt;
  logic                          slicer_on_nxt;
  logic                          slicer_res_nxt;
  logic                          demod_direct_nxt;
  logic                          slicer_follow_nxt;
  logic                          test_err_nxt;
  logic                          loaded_nxt;

  always_comb begin
    en_meta_nxt   = ce ? ser_en_b        : en_meta_r;
    en_sync_nxt   = ce ? en_meta_r       : en_sync_r;
    en_prev_nxt   = ce ? en_sync_r       : en_prev_r;
    osc_meta_nxt  = ce ? osc_power_on    : osc_meta_r;
    osc_sync_nxt  = ce ? osc_meta_r      : osc_sync_r;
    hold_meta_nxt = ce ? slicer_hold_ctl : hold_meta_r;
    hold_sync_nxt = ce ? hold_meta_r     : hold_sync_r;
    // shift register is quiet once the enable is high, so the word is stable
    load          = ce && en_sync_r && !en_prev_r;
    ctl_nxt       = load ? sscw_pkg::sscw_ctl_word_t'(shift_r) : ctl_r;
    loaded_nxt    = load;
  end

  always_comb begin
    main_div_nxt      = div_ratio_of(ctl_nxt);
    ref_div_nxt       = ref_ratio_of(ctl_nxt.ref_div_sel);
    ref_freq_nxt      = ref_khz_of(ref_div_nxt);
    synth_freq_nxt    = synth_khz_of(main_div_nxt);
    op_mode_nxt       = mode_of(ctl_nxt.serial_power_sel, ctl_nxt.ext_mode_sel);
    // reserved combination is flagged, not trusted
    mode_rsvd_nxt     = ctl_nxt.serial_power_sel && !ctl_nxt.ext_mode_sel;
    tx_rx_nxt         = ctl_nxt.tx_rx_sel;
    // only the second sync flop feeds logic; frozen while ce is low
    pll_keep_nxt      = ce ? (ctl_nxt.pll_hold && osc_sync_r) : pll_keep_on;
    slicer_on_nxt     = ctl_nxt.slicer_force;
    slicer_res_nxt    = ctl_nxt.slicer_force;
    demod_direct_nxt  = !ctl_nxt.slicer_force;
    slicer_follow_nxt = ce ? (!ctl_nxt.slicer_force && hold_sync_r) : slicer_ref_follow;
    test_err_nxt      = |{ctl_nxt.test_hi, ctl_nxt.test_lo};
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      en_meta_r         <= 1'b1;
      en_sync_r         <= 1'b1;
      en_prev_r         <= 1'b1;
      osc_meta_r        <= 1'b0;
      osc_sync_r        <= 1'b0;
      hold_meta_r       <= 1'b0;
      hold_sync_r       <= 1'b0;
      ctl_r             <= sscw_pkg::CTL_RESET;
      main_div_ratio    <= sscw_pkg::DIV_BASE;
      ref_div_ratio     <= sscw_pkg::REF_RATIO_0;
      ref_freq_khz      <= ref_khz_of(sscw_pkg::REF_RATIO_0);
      synth_freq_khz    <= synth_khz_of(sscw_pkg::DIV_BASE);
      op_mode           <= sscw_pkg::SSCW_MODE_NORMAL;
      mode_reserved     <= 1'b0;
      tx_rx_sel         <= 1'b0;
      pll_keep_on       <= 1'b0;
      slicer_on         <= 1'b0;
      slicer_res_route  <= 1'b0;
      demod_direct      <= 1'b1;
      slicer_ref_follow <= 1'b0;
      test_bits_err     <= 1'b0;
      word_loaded       <= 1'b0;
    end else begin
      en_meta_r         <= en_meta_nxt;
      en_sync_r         <= en_sync_nxt;
      en_prev_r         <= en_prev_nxt;
      osc_meta_r        <= osc_meta_nxt;
      osc_sync_r        <= osc_sync_nxt;
      hold_meta_r       <= hold_meta_nxt;
      hold_sync_r       <= hold_sync_nxt;
      ctl_r             <= ctl_nxt;
      main_div_ratio    <= main_div_nxt;
      ref_div_ratio     <= ref_div_nxt;
      ref_freq_khz      <= ref_freq_nxt;
      synth_freq_khz    <= synth_freq_nxt;
      op_mode           <= op_mode_nxt;
      mode_reserved     <= mode_rsvd_nxt;
      tx_rx_sel         <= tx_rx_nxt;
      pll_keep_on       <= pll_keep_nxt;
      slicer_on         <= slicer_on_nxt;
      slicer_res_route  <= slicer_res_nxt;
      demod_direct      <= demod_direct_nxt;
      slicer_ref_follow <= slicer_follow_nxt;
      test_bits_err     <= test_err_nxt;
      word_loaded       <= loaded_nxt;
    end
  end

  // checks
  chk_shift_idle_hold: assert property (
    @(posedge ser_clk) ser_en_b |=> $stable(shift_r))
    else $error("shift register moved while enable high");

  chk_shift_bit_order: assert property (
    @(posedge ser_clk) !ser_en_b |=>
      (shift_r === {$past(shift_r[sscw_pkg::WORD_W-2:0]), $past(ser_data)}))
    else $error("serial bit not shifted in at the bottom");

  chk_load_on_rise: assert property (
    @(posedge clk) disable iff (!rst_b)
      (ce && en_sync_r && !en_prev_r) |=>
        (logic'(word_loaded) && (ctl_r == $past(shift_r)))
        ##1 (main_div_ratio == div_ratio_of(ctl_r)))
    else $error("word not taken on enable rise");

  chk_no_load_low: assert property (
    @(posedge clk) disable iff (!rst_b)
      (!ce || !en_sync_r) |=> $stable(ctl_r) && !word_loaded)
    else $error("control changed without enable rise");

  chk_div_ratio_sum: assert property (
    @(posedge clk) disable iff (!rst_b)
      word_loaded |-> (main_div_ratio ==
        sscw_pkg::DIV_BASE + {5'h00, ctl_r.div_field, ctl_r.tx_rx_sel}))
    else $error("main divider ratio wrong");

  chk_div_trx_lsb: assert property (
    @(posedge clk) disable iff (!rst_b)
      word_loaded |-> (main_div_ratio[0] == tx_rx_sel)
        && (tx_rx_sel == ctl_r.tx_rx_sel))
    else $error("tx/rx bit not the divider lsb");

  chk_synth_freq: assert property (
    @(posedge clk) disable iff (!rst_b)
      synth_freq_khz == synth_khz_of(main_div_ratio))
    else $error("synthesized frequency wrong");

  chk_ref_ratio: assert property (
    @(posedge clk) disable iff (!rst_b)
      word_loaded |-> (ref_div_ratio == ref_ratio_of(ctl_r.ref_div_sel))
        && (ref_freq_khz == ref_khz_of(ref_div_ratio)))
    else $error("reference ratio or frequency wrong");

  chk_mode_select: assert property (
    @(posedge clk) disable iff (!rst_b)
      word_loaded |-> (op_mode == mode_of(ctl_r.serial_power_sel, ctl_r.ext_mode_sel))
        && (mode_reserved == (op_mode == sscw_pkg::SSCW_MODE_RSVD)))
    else $error("operating mode wrong");

  chk_pll_keep: assert property (
    @(posedge clk) disable iff (!rst_b)
      ce |=> (pll_keep_on == (ctl_r.pll_hold && $past(osc_sync_r))))
    else $error("loop hold output wrong");

  chk_slicer_route: assert property (
    @(posedge clk) disable iff (!rst_b)
      (slicer_on == ctl_r.slicer_force) && (demod_direct == !slicer_res_route)
        && (!$past(ce)
          || (slicer_ref_follow == (!ctl_r.slicer_force && $past(hold_sync_r)))))
    else $error("slicer routing wrong");

  chk_reset_zero: assert property (
    @(posedge clk) $rose(rst_b) |->
      (ctl_r == sscw_pkg::CTL_RESET) && (op_mode == sscw_pkg::SSCW_MODE_NORMAL))
    else $error("control fields not zero after reset");

  chk_freeze_ce: assert property (
    @(posedge clk) disable iff (!rst_b)
      !ce |=> $stable(ctl_r) && $stable(main_div_ratio))
    else $error("state moved with clock enable low");

endmodule // sscw_top

// [verif/sscw_ctl_model.sv]
`timescale 1ns/10ps
module sscw_ctl_model (
  output logic ser_clk,
  output logic ser_data,
  output logic ser_en_b
);
  initial begin
    ser_clk  = 1'b0;
    ser_data = 1'b0;
    ser_en_b = 1'b1;
  end

  // one burst, top bit of the n lowest first; link clock idle outside
  task automatic send(input logic [25:0] bits, input int n);
    // start off the core clock edge
    #7;
    ser_en_b = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      ser_data = bits[i];
      #16 ser_clk = 1'b1;
      #16 ser_clk = 1'b0;
    end
    ser_en_b = 1'b1;
    ser_data = ~ser_data;
  endtask

  // clock pulses with the enable left high
  task automatic stray(input int n);
    ser_data = 1'b1;
    repeat (n) begin
      #16 ser_clk = 1'b1;
      #16 ser_clk = 1'b0;
    end
  endtask
endmodule // sscw_ctl_model

// [verif/synth_serial_control_word_test.sv]
`timescale 1ns/10ps
module synth_serial_control_word_test;
  typedef struct packed {
    logic [23:0] word;
    logic        osc;
    logic        hold;
    logic [11:0] div;
    logic [4:0]  rdiv;
    logic [1:0]  mode;
  } sscw_row_t;

  logic                 clk, rst_b, ce, ser_clk, ser_data, ser_en_b;
  logic                 osc_power_on, slicer_hold_ctl;
  logic [11:0]          main_div_ratio;
  logic [4:0]           ref_div_ratio;
  logic [13:0]          ref_freq_khz;
  logic [20:0]          synth_freq_khz;
  sscw_pkg::sscw_mode_t op_mode;
  logic                 mode_reserved, tx_rx_sel, pll_keep_on, slicer_on;
  logic                 slicer_res_route, demod_direct, slicer_ref_follow;
  logic                 test_bits_err, word_loaded;
  int                   bad_count = 0;
  int                   tests_run = 0;

  sscw_row_t rows [6] = '{
    '{24'h000000, 1'b0, 1'b1, 12'h880, 5'h04, 2'h1},
    '{24'h020057, 1'b1, 1'b0, 12'h8AF, 5'h10, 2'h1},
    '{24'h0400BF, 1'b1, 1'b1, 12'h8FE, 5'h08, 2'h2},
    '{24'h0E03C0, 1'b1, 1'b1, 12'h881, 5'h0C, 2'h3},
    '{24'h00023F, 1'b0, 1'b0, 12'h8FE, 5'h04, 2'h0},
    '{24'hF1FC00, 1'b1, 1'b1, 12'h880, 5'h04, 2'h1}
  };

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  sscw_ctl_model ctl (.ser_clk(ser_clk), .ser_data(ser_data), .ser_en_b(ser_en_b));

  sscw_top DUT (
    .clk(clk), .rst_b(rst_b), .ce(ce), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_en_b(ser_en_b), .osc_power_on(osc_power_on), .slicer_hold_ctl(slicer_hold_ctl),
    .main_div_ratio(main_div_ratio), .ref_div_ratio(ref_div_ratio),
    .ref_freq_khz(ref_freq_khz), .synth_freq_khz(synth_freq_khz), .op_mode(op_mode),
    .mode_reserved(mode_reserved), .tx_rx_sel(tx_rx_sel), .pll_keep_on(pll_keep_on),
    .slicer_on(slicer_on), .slicer_res_route(slicer_res_route),
    .demod_direct(demod_direct), .slicer_ref_follow(slicer_ref_follow),
    .test_bits_err(test_bits_err), .word_loaded(word_loaded)
  );

  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_load;
    int n;
    n = 0;
    while (word_loaded !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("load pulse", 40'h1, {39'h0, n < 20});
  endtask

  task automatic expect_out(input sscw_row_t r);
    check("ratios", {main_div_ratio, ref_div_ratio}, {r.div, r.rdiv});
    check("freqs", {synth_freq_khz, ref_freq_khz},
          {21'(r.div) * 21'h360, 14'(r.rdiv) * 14'h360});
    check("mode", {op_mode, mode_reserved}, {r.mode, r.word[9] & ~r.word[7]});
    check("flags", {tx_rx_sel, pll_keep_on, slicer_on, slicer_res_route,
          demod_direct, slicer_ref_follow, test_bits_err},
          {r.word[6], r.word[8] & r.osc, r.word[19], r.word[19], ~r.word[19],
           ~r.word[19] & r.hold, |{r.word[23:20], r.word[16:10]}});
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    conclude;
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    osc_power_on = 1'b0;
    slicer_hold_ctl = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    expect_out('{24'h0, 1'b0, 1'b0, 12'h880, 5'h04, 2'h1});
    check("idle load", 40'h0, {39'h0, word_loaded});
    foreach (rows[i]) begin
      @(posedge clk);
      osc_power_on <= rows[i].osc;
      slicer_hold_ctl <= rows[i].hold;
      ctl.send({2'h0, rows[i].word}, 24);
      wait_load;
      expect_out(rows[i]);
    end
    // two extra leading ones fall off the top
    ctl.send({2'h3, 24'h000001}, 26);
    wait_load;
    expect_out('{24'h000001, 1'b1, 1'b1, 12'h882, 5'h04, 2'h1});
    // short burst keeps older bits above
    ctl.send({18'h0, 8'h41}, 8);
    wait_load;
    expect_out('{24'h000141, 1'b1, 1'b1, 12'h883, 5'h04, 2'h1});
    // clocks with enable high must not shift
    ctl.stray(8);
    ctl.send(26'h0, 8);
    wait_load;
    expect_out('{24'h014100, 1'b1, 1'b1, 12'h880, 5'h04, 2'h1});
    // frozen core ignores the pin, then follows it once enabled again
    @(posedge clk);
    ce <= 1'b0;
    osc_power_on <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check("frozen", {word_loaded, pll_keep_on, main_div_ratio}, {2'h1, 12'h880});
    @(posedge clk);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("thawed", 40'h0, {39'h0, pll_keep_on});
    ctl.send(26'h000010, 24);
    wait_load;
    expect_out('{24'h000010, 1'b0, 1'b1, 12'h8A0, 5'h04, 2'h1});
    // reset again in mid-run
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    expect_out('{24'h0, 1'b0, 1'b0, 12'h880, 5'h04, 2'h1});
    repeat (3) @(posedge clk);
    #1;
    check("follow after reset", 40'h1, {39'h0, slicer_ref_follow});
    conclude;
  end
endmodule // synth_serial_control_word_test
